// [rtl/icur_pkg.sv]
// constants, mode codes and state codes of the interchip usb host controller
// assumes a 20 MHz system clock and static mode pins on the board
package icur_pkg;

  // system clock period
  localparam int CLK_NS = 50;

  // mode_select_pins codes, {high, middle, low}
  localparam logic [2:0] MODE_SIX_SE   = 3'h0;
  localparam logic [2:0] MODE_FOUR_SE  = 3'h1;
  localparam logic [2:0] MODE_SIX_LP   = 3'h2;
  localparam logic [2:0] MODE_FOUR_LP  = 3'h3;
  localparam logic [2:0] MODE_UNUSED   = 3'h4;
  localparam logic [2:0] MODE_SERIAL   = 3'h5;
  localparam logic [2:0] MODE_W2IC     = 3'h6;
  localparam logic [2:0] MODE_IC2W_VCC = 3'h7;

  // line symbol layout, {plus, minus}
  localparam int SYM_W    = 2;
  localparam int SYM_PLUS = 1;
  localparam int SYM_MIN  = 0;
  localparam logic [1:0] SYM_IDLE = 2'h2;

  // symbol period on the host pins and bus turnaround time
  localparam int BIT_NS  = 100;
  localparam int TURN_NS = 100;
  localparam int BIT_CYC  = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURN_CYC = (TURN_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ON   = 4'h2,
    ST_SEND = 4'h4,
    ST_OFF  = 4'h8
  } icur_st_t;

endpackage

// [rtl/icur_host.sv]
// interchip usb host controller: fifo and pin driver for the transceiver
// assumes mode pins stay static while running and pin inputs are synchronous
// Summary of operation
// - code 000 selects six-wire single-ended mode
// - code 001 selects four-wire single-ended mode
// - code 010 selects six-wire line pair mode
// - code 011 selects four-wire line pair mode
// - code 101 selects three-wire serial mode
// - serial mode shares data and se0 under enable
// - six-wire single-ended transmit pins are host-driven only
// - six-wire line pair transmit pins host-driven only
// - drive request low only while transmitting
// - four-wire single-ended pins share transmit and receive
// - four-wire line pair pins share line levels
// - code 100 is undefined; it reaches the mode pins but sets mode_error and never sends
// - code 111 selects bridge or converter by wiring
`timescale 1ns/1ns

module icur_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        room;
  } icur_fifo_t;

  icur_fifo_t s_q;
  icur_fifo_t s_d;
  logic       push;
  logic       pop;

  assign in_ready  = s_q.room;
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && s_q.room;
  assign pop       = out_ready && out_valid;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == LAST) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == LAST) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    // registered so that the ready seen upstream comes from a flop
    s_d.room = (s_d.cnt != FULL);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{mem: '0, wp: '0, rp: '0, cnt: '0, room: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module icur_host #(
  parameter int BIT_CYCLES  = icur_pkg::BIT_CYC,
  parameter int TURN_CYCLES = icur_pkg::TURN_CYC,
  parameter int DEPTH       = icur_pkg::FIFO_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [2:0]                  mode_cfg,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  input  wire logic [icur_pkg::SYM_W-1:0]  tx_symbol,
  output logic                             tx_busy,
  output logic                             mode_error,
  output logic                             rx_plus,
  output logic                             rx_minus,
  output logic                             rx_diff,
  output logic [2:0]                       mode_select_pins,
  output logic                             drive_request_low,
  output logic                             host_a_o,
  output logic                             host_a_oe,
  input  wire logic                        host_a_i,
  output logic                             host_b_o,
  output logic                             host_b_oe,
  input  wire logic                        host_b_i,
  input  wire logic                        received_plus_line_out,
  input  wire logic                        received_minus_line_out,
  input  wire logic                        differential_receiver_out,
  input  wire logic                        host_plus_aux_out,
  input  wire logic                        host_minus_aux_out
);
  localparam logic [icur_pkg::CNT_W-1:0] BIT_LOAD =
    icur_pkg::CNT_W'(BIT_CYCLES - 1);
  localparam logic [icur_pkg::CNT_W-1:0] TURN_LOAD =
    icur_pkg::CNT_W'(TURN_CYCLES - 1);

  typedef struct packed {
    icur_pkg::icur_st_t              st;
    logic [2:0]                      mode;
    logic                            err;
    logic [icur_pkg::CNT_W-1:0]      cnt;
    logic                            req_n;
    logic                            a_o;
    logic                            a_oe;
    logic                            b_o;
    logic                            b_oe;
    logic                            rx_p;
    logic                            rx_m;
    logic                            rx_d;
    logic                            busy;
  } icur_host_t;

  icur_host_t                   s_q;
  icur_host_t                   s_d;
  logic                         f_valid;
  logic                         f_ready;
  logic [icur_pkg::SYM_W-1:0]   f_data;

  // six-wire modes keep transmit and receive on separate pins
  function automatic logic is_six(input logic [2:0] m);
    is_six = (m == icur_pkg::MODE_SIX_SE) || (m == icur_pkg::MODE_SIX_LP);
  endfunction

  // modes that carry transmit bit and se0 instead of line levels
  function automatic logic is_se(input logic [2:0] m);
    is_se = (m == icur_pkg::MODE_SIX_SE) || (m == icur_pkg::MODE_FOUR_SE)
         || (m == icur_pkg::MODE_SERIAL);
  endfunction

  // bridge and converter modes have the enable pin tied high on board
  function automatic logic uses_req(input logic [2:0] m);
    uses_req = !((m == icur_pkg::MODE_W2IC)
              || (m == icur_pkg::MODE_IC2W_VCC));
  endfunction

  // host pin levels for one line symbol
  function automatic logic [1:0] pin_code(input logic [2:0] m,
                                          input logic [1:0] sym);
    logic p;
    logic n;
    p = sym[icur_pkg::SYM_PLUS];
    n = sym[icur_pkg::SYM_MIN];
    if (is_se(m)) begin
      pin_code = {p, !p && !n};
    end else begin
      pin_code = {p, n};
    end
  endfunction

  icur_fifo #(
    .WIDTH (icur_pkg::SYM_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_symbol),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // a symbol leaves the fifo only at a bit boundary while driving
  assign f_ready = f_valid && (s_q.cnt == icur_pkg::CNT_ZERO)
                && ((s_q.st == icur_pkg::ST_ON)
                 || (s_q.st == icur_pkg::ST_SEND));

  always_comb begin
    logic [1:0] pc;
    logic [1:0] idle_pc;
    pc = pin_code(s_q.mode, f_data);
    idle_pc = pin_code(s_q.mode, icur_pkg::SYM_IDLE);
    s_d = s_q;
    if (s_q.cnt != icur_pkg::CNT_ZERO) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end

    // receive side, sampled every cycle
    if (is_six(s_q.mode)) begin
      s_d.rx_p = received_plus_line_out;
      s_d.rx_m = received_minus_line_out;
    end else if (s_q.mode == icur_pkg::MODE_SERIAL) begin
      s_d.rx_p = host_a_i && !host_b_i;
      s_d.rx_m = !host_a_i && !host_b_i;
    end else begin
      s_d.rx_p = host_a_i;
      s_d.rx_m = host_b_i;
    end
    if (uses_req(s_q.mode)) begin
      s_d.rx_d = differential_receiver_out;
    end else begin
      s_d.rx_d = host_a_i;
    end

    case (s_q.st)
      icur_pkg::ST_IDLE: begin
        s_d.req_n = 1'b1;
        s_d.busy = 1'b0;
        s_d.mode = mode_cfg;
        s_d.err = (mode_cfg == icur_pkg::MODE_UNUSED);
        // six-wire pins stay driven; new code used so shared pins never lag
        s_d.a_oe = is_six(mode_cfg);
        s_d.b_oe = is_six(mode_cfg);
        s_d.a_o = idle_pc[1];
        s_d.b_o = idle_pc[0];
        if (f_valid && !s_q.err && (mode_cfg == s_q.mode)) begin
          s_d.st = icur_pkg::ST_ON;
          s_d.busy = 1'b1;
          s_d.req_n = !uses_req(s_q.mode);
          s_d.cnt = TURN_LOAD;
        end
      end
      icur_pkg::ST_ON, icur_pkg::ST_SEND: begin
        if (s_q.cnt == icur_pkg::CNT_ZERO) begin
          if (f_valid) begin
            // pins driven only after the device has released them
            s_d.st = icur_pkg::ST_SEND;
            s_d.a_oe = 1'b1;
            s_d.b_oe = 1'b1;
            s_d.a_o = pc[1];
            s_d.b_o = pc[0];
            s_d.cnt = BIT_LOAD;
          end else begin
            s_d.st = icur_pkg::ST_OFF;
            s_d.a_o = idle_pc[1];
            s_d.b_o = idle_pc[0];
            s_d.a_oe = is_six(s_q.mode);
            s_d.b_oe = is_six(s_q.mode);
            s_d.cnt = TURN_LOAD;
          end
        end
      end
      icur_pkg::ST_OFF: begin
        // request rises after the turnaround; shared-pin drivers are off by then, six-wire pins stay driven
        if (s_q.cnt == icur_pkg::CNT_ZERO) begin
          s_d.st = icur_pkg::ST_IDLE;
          s_d.req_n = 1'b1;
          s_d.busy = 1'b0;
        end
      end
      default: begin
        s_d.st = icur_pkg::ST_IDLE;
        s_d.req_n = 1'b1;
        s_d.a_oe = 1'b0;
        s_d.b_oe = 1'b0;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: icur_pkg::ST_IDLE, mode: icur_pkg::MODE_SIX_SE,
               err: 1'b0, cnt: icur_pkg::CNT_ZERO, req_n: 1'b1,
               a_o: 1'b0, a_oe: 1'b0, b_o: 1'b0, b_oe: 1'b0,
               rx_p: 1'b0, rx_m: 1'b0, rx_d: 1'b0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // aux outputs are high impedance outside six-wire modes; not read here
  assign mode_select_pins  = s_q.mode;
  assign drive_request_low = s_q.req_n;
  assign host_a_o          = s_q.a_o;
  assign host_a_oe         = s_q.a_oe;
  assign host_b_o          = s_q.b_o;
  assign host_b_oe         = s_q.b_oe;
  assign rx_plus           = s_q.rx_p;
  assign rx_minus          = s_q.rx_m;
  assign rx_diff           = s_q.rx_d;
  assign tx_busy           = s_q.busy;
  assign mode_error        = s_q.err;
endmodule

// [test/icur_host_props.sv]
// assertions on the icur_host ports, bound into every instance
// assumes mode_cfg only changes while no transmission runs
`timescale 1ns/1ns
module icur_host_props (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [2:0] mode_cfg,
  input wire logic       tx_busy,
  input wire logic       rx_plus,
  input wire logic       rx_minus,
  input wire logic       rx_diff,
  input wire logic [2:0] mode_select_pins,
  input wire logic       drive_request_low,
  input wire logic       host_a_oe,
  input wire logic       host_b_oe,
  input wire logic       host_a_i,
  input wire logic       host_b_i,
  input wire logic       received_plus_line_out,
  input wire logic       received_minus_line_out,
  input wire logic       differential_receiver_out
);
  logic [1:0] calm_q;
  logic [2:0] last_q;
  wire  [2:0] m    = mode_select_pins;
  wire        six  = m == 3'h0 || m == 3'h2;
  wire        bidi = m == 3'h1 || m == 3'h3 || m == 3'h5;
  wire        brg  = m[2:1] == 2'b11;
  wire        calm = calm_q == 2'h3;
  // receive paths and six-wire enables are only judged once the latched mode has settled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      calm_q <= 2'h0;
      last_q <= 3'h0;
    end else begin
      last_q <= m;
      calm_q <= (m != last_q) ? 2'h0 : calm ? calm_q : calm_q + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req_start; bidi && $fell(drive_request_low); endsequence
  sequence s_pins_taken; ##[1:4] (host_a_oe && host_b_oe); endsequence
  property p_turn_on; s_req_start |-> s_pins_taken; endproperty
  a_turn_on: assert property (p_turn_on) else $error("pins late");
  property p_bidi_req; bidi && host_a_oe |-> !drive_request_low; endproperty
  a_bidi_req: assert property (p_bidi_req) else $error("pin clash");
  property p_release;
    bidi && $rose(drive_request_low) |-> !host_a_oe && !host_b_oe;
  endproperty
  a_release: assert property (p_release) else $error("pins held");
  property p_brg_req; brg |-> drive_request_low; endproperty
  a_brg_req: assert property (p_brg_req) else $error("bridge request");
  property p_unused; m == 3'h4 |-> drive_request_low && !tx_busy; endproperty
  a_unused: assert property (p_unused) else $error("code 100 sent");
  property p_six_oe; six && calm |-> host_a_oe && host_b_oe; endproperty
  a_six_oe: assert property (p_six_oe) else $error("six-wire float");
  property p_rx_six;
    six && calm |=> rx_plus == $past(received_plus_line_out) &&
      rx_minus == $past(received_minus_line_out);
  endproperty
  a_rx_six: assert property (p_rx_six) else $error("six-wire rx");
  property p_rx_diff;
    !brg && m != 3'h4 && calm |=> rx_diff == $past(differential_receiver_out);
  endproperty
  a_rx_diff: assert property (p_rx_diff) else $error("rx diff");
  property p_rx_four;
    (m == 3'h1 || m == 3'h3) && calm |=> rx_plus == $past(host_a_i) &&
      rx_minus == $past(host_b_i);
  endproperty
  a_rx_four: assert property (p_rx_four) else $error("shared rx");
  property p_rx_ser;
    m == 3'h5 && calm |=> rx_minus == (!$past(host_a_i) && !$past(host_b_i));
  endproperty
  a_rx_ser: assert property (p_rx_ser) else $error("serial rx");
  property p_mode_hold; tx_busy |-> m == mode_cfg; endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode");
endmodule
bind icur_host icur_host_props icur_host_props_inst (
  .clk(clk), .resetn(resetn), .mode_cfg(mode_cfg), .tx_busy(tx_busy),
  .rx_plus(rx_plus), .rx_minus(rx_minus), .rx_diff(rx_diff),
  .mode_select_pins(mode_select_pins), .host_a_i(host_a_i),
  .drive_request_low(drive_request_low), .host_b_i(host_b_i),
  .host_a_oe(host_a_oe), .host_b_oe(host_b_oe),
  .received_plus_line_out(received_plus_line_out),
  .received_minus_line_out(received_minus_line_out),
  .differential_receiver_out(differential_receiver_out));

// [test/icur_dev_model.sv]
// behavioural transceiver on the far side of icur_host
// assumes the bench gives the peripheral line levels when nobody sends
`timescale 1ns/1ns
module icur_dev_model (
  input  wire logic       clk,
  input  wire logic [2:0] mode,
  input  wire logic       req_n,
  input  wire logic       a_o,
  input  wire logic       a_oe,
  input  wire logic       b_o,
  input  wire logic       b_oe,
  input  wire logic       line_p,
  input  wire logic       line_m,
  output logic            a_i,
  output logic            b_i,
  output logic            rx_p,
  output logic            rx_m,
  output logic            rcv,
  output logic            dn_p,
  output logic            dn_m
);
  logic tog = 1'b0;
  logic six, brg, se, dev_en, tx_on;
  // a released wire toggles so a stale level is never read
  always @(posedge clk) tog <= ~tog;
  always_comb begin
    six    = mode == 3'h0 || mode == 3'h2;
    brg    = mode[2:1] == 2'b11;
    se     = mode == 3'h0 || mode == 3'h1 || mode == 3'h5;
    dev_en = brg ? !a_oe : !six && req_n && mode != 3'h4;
    tx_on  = brg ? a_oe : !req_n;
    a_i    = a_oe ? a_o : dev_en ? line_p : tog;
    b_i    = b_oe ? b_o : !dev_en ? !tog :
             mode == 3'h5 ? !line_p && !line_m : line_m;
    {dn_p, dn_m} = !tx_on ? {line_p, line_m} : !se ? {a_i, b_i} :
                   b_i ? 2'b00 : {a_i, !a_i};
    rx_p   = six ? dn_p : 1'bz;
    rx_m   = six ? dn_m : 1'bz;
    rcv    = brg ? 1'bz : dn_p;
  end
endmodule

// [test/test_icur_host.sv]
// self-checking bench for icur_host beside a transceiver model
// assumes a 20 MHz clock and two-cycle symbol and turnaround times
`timescale 1ns/1ns
module test_icur_host;
  localparam logic [2:0] MODES [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6,
                                       3'h7};
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] mode_cfg = 3'h0;
  logic       tx_valid = 1'b0;
  logic [1:0] tx_symbol = 2'h2;
  logic       line_p = 1'b1;
  logic       line_m = 1'b0;
  logic       tx_ready, tx_busy, mode_error, rx_plus, rx_minus, rx_diff;
  logic [2:0] mode_select_pins;
  logic       drive_request_low, host_a_o, host_a_oe, host_a_i;
  logic       host_b_o, host_b_oe, host_b_i, rx_p, rx_m, rcv, dn_p, dn_m;
  logic [1:0] last = 2'h2;
  logic [1:0] seen [$];
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  always #25 clk = ~clk;
  icur_host #(.BIT_CYCLES(2), .TURN_CYCLES(2), .DEPTH(8)) icur_host_inst (
    .clk(clk), .resetn(resetn), .mode_cfg(mode_cfg), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_symbol(tx_symbol), .tx_busy(tx_busy),
    .mode_error(mode_error), .rx_plus(rx_plus), .rx_minus(rx_minus),
    .rx_diff(rx_diff), .mode_select_pins(mode_select_pins),
    .drive_request_low(drive_request_low), .host_a_o(host_a_o),
    .host_a_oe(host_a_oe), .host_a_i(host_a_i), .host_b_o(host_b_o),
    .host_b_oe(host_b_oe), .host_b_i(host_b_i),
    .received_plus_line_out(rx_p), .received_minus_line_out(rx_m),
    .differential_receiver_out(rcv), .host_plus_aux_out(rx_p),
    .host_minus_aux_out(rx_m));
  icur_dev_model icur_dev_model_inst (
    .clk(clk), .mode(mode_select_pins), .req_n(drive_request_low),
    .a_o(host_a_o), .a_oe(host_a_oe), .b_o(host_b_o), .b_oe(host_b_oe),
    .line_p(line_p), .line_m(line_m), .a_i(host_a_i), .b_i(host_b_i),
    .rx_p(rx_p), .rx_m(rx_m), .rcv(rcv), .dn_p(dn_p), .dn_m(dn_m));
  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  // log each new downstream symbol while the host really sends
  always @(posedge clk) begin
    if (tx_busy === 1'b1 && host_a_oe === 1'b1 && {dn_p, dn_m} !== last &&
        (drive_request_low === 1'b0 || mode_select_pins[2:1] == 2'b11)) begin
      seen.push_back({dn_p, dn_m});
      last = {dn_p, dn_m};
    end
  end
  task automatic t_receive;
    logic six;
    foreach (MODES[i]) begin
      six = MODES[i] == 3'h0 || MODES[i] == 3'h2;
      mode_cfg = MODES[i];
      for (int s = 0; s < 2; s++) begin
        {line_p, line_m} = (s == 1) ? 2'b10 : 2'b01;
        tick(4);
        check({5'h0, mode_select_pins}, {5'h0, MODES[i]});
        check({6'h0, rx_plus, rx_minus}, {6'h0, line_p, line_m});
        check({7'h0, rx_diff}, {7'h0, line_p});
        check({6'h0, drive_request_low, host_a_oe}, {7'h1, six});
      end
    end
  endtask
  task automatic t_send;
    int n;
    foreach (MODES[i]) begin
      mode_cfg = MODES[i];
      tick(4);
      seen.delete();
      last = 2'h2;
      tx_valid = 1'b1;
      for (n = 0; n < 3; n++) begin
        tx_symbol = (n == 1) ? 2'h0 : 2'h1;
        tick(1);
      end
      tx_valid = 1'b0;
      for (n = 0; n < 40 && tx_busy !== 1'b0; n++) tick(1);
      check({2'h0, seen[0], seen[1], seen[2]}, 8'h11);
      check({7'h0, drive_request_low}, 8'h01);
    end
  endtask
  task automatic t_full;
    int n;
    mode_cfg = 3'h4;
    tick(4);
    check({7'h0, mode_error}, 8'h01);
    tx_symbol = 2'h1;
    tx_valid = 1'b1;
    for (n = 0; n < 12 && tx_ready === 1'b1; n++) tick(1);
    tx_valid = 1'b0;
    check(n[7:0], 8'h08);
    check({6'h0, drive_request_low, tx_busy}, 8'h02);
    // a legal mode lets the held symbols drain
    mode_cfg = 3'h0;
    tick(6);
    for (n = 0; n < 60 && tx_busy !== 1'b0; n++) tick(1);
    check({6'h0, tx_ready, mode_error}, 8'h02);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #5 resetn = 1'b1;
    tick(2);
    t_receive();
    t_send();
    t_full();
    give_verdict();
  end
endmodule
